// ===== hdl/bdsb_pkg.sv
package bdsb_pkg;
    // debug_status_control bit positions
    localparam int unsigned POS_PERMIT = 7;
    localparam int unsigned POS_ACTIVE = 6;
    localparam int unsigned POS_BKPT_EN = 5;
    localparam int unsigned POS_FORCE_TAG = 4;
    localparam int unsigned POS_CLOCK_SEL = 3;
    localparam int unsigned POS_WAIT_STOP = 2;
    localparam int unsigned POS_WAIT_FAIL = 1;
    localparam int unsigned POS_DATA_FAIL = 0;
    // reset values
    localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
    localparam logic [15:0] RST_BKPT_ADDR = 16'h0000;
    // writable control bits of the write-control command
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hB8;
    // cpu run state seen by the debug controller
    typedef enum logic [1:0] {
        BDSB_RUN,
        BDSB_WAIT_STOP,
        BDSB_BACKGROUND
    } bdsb_cpu_t;
endpackage

// ===== hdl/bdsb_bkpt_if.sv
`timescale 1ns/1ps
interface bdsb_bkpt_if;
    logic enable;
    logic force_sel;
    logic [15:0] addr;
    logic [15:0] cpu_addr;
    logic cpu_addr_valid;
    logic opcode_fetch;
    logic hit_force;
    logic hit_tag;
    modport ctrl (output enable, output force_sel, output addr, output cpu_addr,
        output cpu_addr_valid, output opcode_fetch, input hit_force, input hit_tag);
    modport cmp (input enable, input force_sel, input addr, input cpu_addr,
        input cpu_addr_valid, input opcode_fetch, output hit_force, output hit_tag);
endinterface

// ===== hdl/bdsb_bkpt_cmp.sv
`timescale 1ns/1ps
module bdsb_bkpt_cmp
(
    bdsb_bkpt_if.cmp bk
);
    import bdsb_pkg::*;
    logic match;

    // single comparator; disabled enable masks everything else
    assign match = bk.enable && bk.cpu_addr_valid && (bk.cpu_addr == bk.addr);
    // force: any bus cycle matching, opcode or not
    assign bk.hit_force = match && bk.force_sel;
    // tag: only opcode fetches are marked
    assign bk.hit_tag = match && !bk.force_sel && bk.opcode_fetch;
endmodule

// ===== hdl/bdsb_top.sv
`timescale 1ns/1ps
module bdsb_top
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    input wire logic WRITE_CONTROL_I,
    input wire logic [7:0] CONTROL_DATA_I,
    output logic [7:0] STATUS_O,
    input wire logic WRITE_BREAK_I,
    input wire logic [15:0] BKPT_DATA_I,
    output logic [15:0] BKPT_ADDR_O,
    input wire logic BACKGROUND_CMD_I,
    input wire logic CPU_GO_I,
    input wire logic CPU_WAIT_STOP_I,
    input wire logic CPU_WAKE_I,
    input wire logic MEM_CMD_FAIL_WAIT_I,
    input wire logic [15:0] CPU_ADDR_I,
    input wire logic CPU_ADDR_VALID_I,
    input wire logic OPCODE_FETCH_I,
    input wire logic INSTR_BOUNDARY_I,
    input wire logic TAG_AT_QUEUE_END_I,
    output logic ENTER_BACKGROUND_O,
    output logic SOFT_INT_REQ_O,
    output logic TAG_OPCODE_O,
    output logic CPU_HALTED_O,
    output logic COMM_CLK_BUS_O
);
    import bdsb_pkg::*;

    bdsb_bkpt_if bk();
    bdsb_cpu_t cpu_state;
    bdsb_cpu_t next_cpu_state;
    logic background_permit;
    logic breakpoint_enable;
    logic force_tag_select;
    logic comm_clock_select;
    logic wait_stop_failure;
    logic wait_stop_latched;
    logic [15:0] debug_breakpoint_address;
    logic force_pending;
    logic break_event;
    logic background_active_flag;
    logic wait_stop_status;

    assign bk.enable = breakpoint_enable;
    assign bk.force_sel = force_tag_select;
    assign bk.addr = debug_breakpoint_address;
    assign bk.cpu_addr = CPU_ADDR_I;
    assign bk.cpu_addr_valid = CPU_ADDR_VALID_I;
    assign bk.opcode_fetch = OPCODE_FETCH_I;

    bdsb_bkpt_cmp u_cmp
    (
        .bk(bk)
    );

    assign background_active_flag = (cpu_state == BDSB_BACKGROUND);

    // control bits; status bits are never taken from the write data
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            background_permit <= RST_STATUS_CONTROL[POS_PERMIT];
            breakpoint_enable <= RST_STATUS_CONTROL[POS_BKPT_EN];
            force_tag_select <= RST_STATUS_CONTROL[POS_FORCE_TAG];
            comm_clock_select <= RST_STATUS_CONTROL[POS_CLOCK_SEL];
        end
        else if (CLK_EN_I && WRITE_CONTROL_I)
        begin
            // no way to revoke permission while already halted
            if (!background_active_flag)
            begin
                background_permit <= background_permit | CONTROL_DATA_I[POS_PERMIT];
            end
            breakpoint_enable <= CONTROL_DATA_I[POS_BKPT_EN];
            force_tag_select <= CONTROL_DATA_I[POS_FORCE_TAG];
            comm_clock_select <= CONTROL_DATA_I[POS_CLOCK_SEL];
        end
    end

    // breakpoint address, reachable only from the serial command port
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            debug_breakpoint_address <= RST_BKPT_ADDR;
        end
        else if (CLK_EN_I && WRITE_BREAK_I)
        begin
            debug_breakpoint_address <= BKPT_DATA_I;
        end
    end

    // force request held until the next instruction boundary
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            force_pending <= 1'b0;
        end
        else if (CLK_EN_I)
        begin
            if (!breakpoint_enable || cpu_state != BDSB_RUN)
            begin
                force_pending <= 1'b0;
            end
            else if (bk.hit_force)
            begin
                force_pending <= 1'b1;
            end
            else if (INSTR_BOUNDARY_I)
            begin
                force_pending <= 1'b0;
            end
        end
    end

    // a breakpoint is due: pending force at boundary, or tag reaching end
    assign break_event = (cpu_state == BDSB_RUN) && breakpoint_enable
        && ((force_pending && INSTR_BOUNDARY_I)
        || (!force_tag_select && TAG_AT_QUEUE_END_I));

    // cpu run state
    always_comb
    begin
        next_cpu_state = cpu_state;
        unique case (cpu_state)
            BDSB_RUN:
            begin
                if (BACKGROUND_CMD_I && background_permit)
                    next_cpu_state = BDSB_BACKGROUND;
                else if (break_event && background_permit)
                    next_cpu_state = BDSB_BACKGROUND;
                else if (CPU_WAIT_STOP_I)
                    next_cpu_state = BDSB_WAIT_STOP;
            end
            BDSB_WAIT_STOP:
            begin
                if (BACKGROUND_CMD_I && background_permit)
                    next_cpu_state = BDSB_BACKGROUND;
                else if (CPU_WAKE_I)
                    next_cpu_state = BDSB_RUN;
            end
            BDSB_BACKGROUND:
            begin
                if (CPU_GO_I)
                    next_cpu_state = BDSB_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            cpu_state <= BDSB_RUN;
        else if (CLK_EN_I)
            cpu_state <= next_cpu_state;
    end

    // remembers that background was entered out of wait or stop
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            wait_stop_latched <= 1'b0;
        else if (CLK_EN_I)
        begin
            if (cpu_state == BDSB_WAIT_STOP && next_cpu_state == BDSB_BACKGROUND)
                wait_stop_latched <= 1'b1;
            else if (next_cpu_state != BDSB_BACKGROUND)
                wait_stop_latched <= 1'b0;
        end
    end

    assign wait_stop_status = (cpu_state == BDSB_WAIT_STOP) || wait_stop_latched;

    // failure flag: set on conflict, cleared by the next go; set wins
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            wait_stop_failure <= 1'b0;
        else if (CLK_EN_I)
        begin
            if (MEM_CMD_FAIL_WAIT_I)
                wait_stop_failure <= 1'b1;
            else if (CPU_GO_I && cpu_state == BDSB_BACKGROUND)
                wait_stop_failure <= 1'b0;
        end
    end

    // status byte for the read-status command; flags come from state only
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            STATUS_O <= RST_STATUS_CONTROL;
            BKPT_ADDR_O <= RST_BKPT_ADDR;
        end
        else if (CLK_EN_I)
        begin
            STATUS_O[POS_PERMIT] <= background_permit;
            STATUS_O[POS_ACTIVE] <= background_active_flag;
            STATUS_O[POS_BKPT_EN] <= breakpoint_enable;
            STATUS_O[POS_FORCE_TAG] <= force_tag_select;
            STATUS_O[POS_CLOCK_SEL] <= comm_clock_select;
            STATUS_O[POS_WAIT_STOP] <= wait_stop_status;
            STATUS_O[POS_WAIT_FAIL] <= wait_stop_failure;
            STATUS_O[POS_DATA_FAIL] <= 1'b0;
            BKPT_ADDR_O <= debug_breakpoint_address;
        end
    end

    // cpu-facing requests; breakpoint without permit becomes an interrupt
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ENTER_BACKGROUND_O <= 1'b0;
            SOFT_INT_REQ_O <= 1'b0;
            TAG_OPCODE_O <= 1'b0;
        end
        else if (CLK_EN_I)
        begin
            ENTER_BACKGROUND_O <= (cpu_state != BDSB_BACKGROUND)
                && (next_cpu_state == BDSB_BACKGROUND);
            SOFT_INT_REQ_O <= break_event && !background_permit;
            TAG_OPCODE_O <= bk.hit_tag;
        end
    end

    assign CPU_HALTED_O = background_active_flag;
    assign COMM_CLK_BUS_O = comm_clock_select;

    chk_permit_sticky: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        $past(background_permit) && $past(CLK_EN_I) |-> background_permit)
        else $error("permit bit dropped without reset");
    chk_permit_locked: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I && WRITE_CONTROL_I && background_active_flag |=> $stable(background_permit))
        else $error("permit changed while in background");
    chk_status_active: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I |=> STATUS_O[POS_ACTIVE] == $past(cpu_state == BDSB_BACKGROUND))
        else $error("active flag does not follow cpu state");
    chk_disabled_quiet: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        !breakpoint_enable |-> !bk.hit_force && !bk.hit_tag && !break_event)
        else $error("breakpoint active while disabled");
    chk_force_enter: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I && background_permit && break_event |=> background_active_flag)
        else $error("breakpoint did not enter background");
    chk_tag_mark: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I && bk.hit_tag |=> TAG_OPCODE_O)
        else $error("matching opcode fetch not tagged");
    chk_wait_exit: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I && cpu_state == BDSB_WAIT_STOP && BACKGROUND_CMD_I && background_permit
        |=> background_active_flag ##0 wait_stop_status)
        else $error("background command did not leave wait or stop");
    chk_fail_set: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I && MEM_CMD_FAIL_WAIT_I |=> wait_stop_failure ##1 STATUS_O[POS_WAIT_FAIL]
        || !$past(CLK_EN_I))
        else $error("failure flag not raised");
    chk_data_fail_zero: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        !STATUS_O[POS_DATA_FAIL])
        else $error("data valid failure bit set");
    chk_soft_int_route: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESET_N_I)
        CLK_EN_I && break_event && !background_permit |=> SOFT_INT_REQ_O && !background_active_flag)
        else $error("breakpoint without permit not an interrupt");

    cov_force_break: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        force_pending && INSTR_BOUNDARY_I && background_permit);
    cov_tag_break: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        TAG_OPCODE_O ##[1:20] (TAG_AT_QUEUE_END_I && break_event));
    cov_wait_exit: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        cpu_state == BDSB_WAIT_STOP ##1 background_active_flag);
    cov_soft_int: cover property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) SOFT_INT_REQ_O);
endmodule

// ===== bench/bdsb_host_model.sv
`timescale 1ns/1ps
module bdsb_host_model
(
    input wire logic clk_i,
    input wire logic [7:0] status_i,
    output logic write_control_o,
    output logic [7:0] control_data_o,
    output logic load_break_o,
    output logic [15:0] bkpt_data_o,
    output logic background_cmd_o
);
    import bdsb_pkg::*;
    // every command line idle until the bench asks for one
    initial
    begin
        write_control_o = 1'b0;
        control_data_o = 8'h00;
        load_break_o = 1'b0;
        bkpt_data_o = 16'h0000;
        background_cmd_o = 1'b0;
    end
    // write-control command; data inverted once released so stale values never match
    task automatic write_ctrl(input logic [7:0] d);
        @(posedge clk_i);
        #1;
        control_data_o = d;
        write_control_o = 1'b1;
        @(posedge clk_i);
        #1;
        write_control_o = 1'b0;
        control_data_o = ~d;
    endtask
    // write-breakpoint command, the only way into the address register
    task automatic set_break(input logic [15:0] a);
        @(posedge clk_i);
        #1;
        bkpt_data_o = a;
        load_break_o = 1'b1;
        @(posedge clk_i);
        #1;
        load_break_o = 1'b0;
        bkpt_data_o = ~a;
    endtask
    // background command, also the first step of wait/stop recovery
    task automatic background();
        @(posedge clk_i);
        #1;
        background_cmd_o = 1'b1;
        @(posedge clk_i);
        #1;
        background_cmd_o = 1'b0;
    endtask
    // read-status command, used to confirm the active flag
    task automatic read_status(output logic [7:0] s);
        @(posedge clk_i);
        #1;
        s = status_i;
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bdsb_pkg::*;
    localparam logic [5:0] GO = 6'h01;
    localparam logic [5:0] WAIT_IN = 6'h02;
    localparam logic [5:0] WAKE = 6'h04;
    localparam logic [5:0] MFAIL = 6'h08;
    localparam logic [5:0] BOUND = 6'h10;
    localparam logic [5:0] QEND = 6'h20;
    logic clk_sys;
    logic reset_n;
    logic [5:0] ev;
    logic [15:0] cpu_addr;
    logic addr_valid;
    logic fetch;
    logic wr_ctrl, wr_bkpt, bg_cmd;
    logic [7:0] ctrl_data;
    logic [15:0] bkpt_data;
    logic [7:0] status;
    logic [15:0] bkpt_addr;
    logic enter_bg, soft_int, tag_op, halted, comm_bus;
    logic clk_en;
    int err_count = 0;
    int n_tests = 0;
    int n_enter, n_soft, n_tag;
    bdsb_top u_bdsb_top (.CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .CLK_EN_I(clk_en),
        .WRITE_CONTROL_I(wr_ctrl), .CONTROL_DATA_I(ctrl_data), .STATUS_O(status),
        .WRITE_BREAK_I(wr_bkpt), .BKPT_DATA_I(bkpt_data), .BKPT_ADDR_O(bkpt_addr),
        .BACKGROUND_CMD_I(bg_cmd), .CPU_GO_I(ev[0]), .CPU_WAIT_STOP_I(ev[1]),
        .CPU_WAKE_I(ev[2]), .MEM_CMD_FAIL_WAIT_I(ev[3]), .CPU_ADDR_I(cpu_addr),
        .CPU_ADDR_VALID_I(addr_valid), .OPCODE_FETCH_I(fetch), .INSTR_BOUNDARY_I(ev[4]),
        .TAG_AT_QUEUE_END_I(ev[5]), .ENTER_BACKGROUND_O(enter_bg),
        .SOFT_INT_REQ_O(soft_int), .TAG_OPCODE_O(tag_op), .CPU_HALTED_O(halted),
        .COMM_CLK_BUS_O(comm_bus));
    bdsb_host_model u_host (.clk_i(clk_sys), .status_i(status), .write_control_o(wr_ctrl),
        .control_data_o(ctrl_data), .load_break_o(wr_bkpt), .bkpt_data_o(bkpt_data),
        .background_cmd_o(bg_cmd));
    // 200 MHz bus clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // count pulses mid-cycle, clear of the edge that launches them
    always @(negedge clk_sys)
    begin
        if (enter_bg === 1'b1) n_enter++;
        if (soft_int === 1'b1) n_soft++;
        if (tag_op === 1'b1) n_tag++;
    end
    task automatic check_word(input string w, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic check_flag(input string w, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic see_status(input string w, input logic [7:0] e);
        logic [7:0] s;
        u_host.read_status(s);
        check_word(w, {8'h00, e}, {8'h00, s});
    endtask
    task automatic pulse(input logic [5:0] m);
        step(1);
        ev = m;
        step(1);
        ev = 6'h00;
    endtask
    // one cpu bus cycle; address inverted afterwards, never left stale
    task automatic bus(input logic [15:0] a, input logic f);
        step(1);
        cpu_addr = a;
        addr_valid = 1'b1;
        fetch = f;
        step(1);
        cpu_addr = ~a;
        addr_valid = 1'b0;
        fetch = 1'b0;
    endtask
    // bounded wait, a lost halt must not hang the run
    task automatic wait_halt();
        for (int i = 0; i < 10 && halted !== 1'b1; i++)
            step(1);
    endtask
    task automatic arm(input logic [7:0] c);
        u_host.write_ctrl(c);
        step(2);
        n_enter = 0;
        n_soft = 0;
        n_tag = 0;
    endtask
    task automatic test_reset();
        see_status("status", RST_STATUS_CONTROL);
        check_word("bkpt", RST_BKPT_ADDR, bkpt_addr);
        check_flag("comm_bus", 1'b0, comm_bus);
        $display("test reset done");
    endtask
    // permit still clear: breakpoint must end in a software interrupt
    task automatic test_soft_int();
        u_host.set_break(16'h1234);
        arm(8'h30);
        bus(16'h1235, 1'b1);
        pulse(BOUND);
        step(3);
        check_word("soft int miss", 16'h0000, 16'(n_soft));
        bus(16'h1234, 1'b1);
        pulse(BOUND);
        step(3);
        check_word("soft int", 16'h0001, 16'(n_soft));
        u_host.background();
        step(3);
        check_flag("halted", 1'b0, halted);
        $display("test soft int done");
    endtask
    task automatic test_ctrl();
        arm(8'hFF);
        see_status("ctrl all", 8'hB8);
        check_flag("comm_bus", 1'b1, comm_bus);
        arm(8'h00);
        see_status("permit kept", 8'h80);
        check_flag("comm_bus", 1'b0, comm_bus);
        u_host.set_break(16'hA55A);
        arm(8'h90);
        check_word("bkpt", 16'hA55A, bkpt_addr);
        bus(16'hA55A, 1'b1);
        pulse(BOUND);
        step(3);
        check_flag("halted", 1'b0, halted);
        check_word("breaks", 16'h0000, 16'(n_tag + n_soft));
        $display("test ctrl done");
    endtask
    task automatic test_break();
        arm(8'hB0);
        bus(16'hA55A, 1'b0);
        step(3);
        check_flag("early halt", 1'b0, halted);
        pulse(BOUND);
        wait_halt();
        step(2);
        check_word("enter", 16'h0001, 16'(n_enter));
        see_status("active", 8'hF0);
        // breakpoint moved while halted, as a host normally does
        u_host.set_break(16'h0F0F);
        step(1);
        check_word("bkpt halted", 16'h0F0F, bkpt_addr);
        pulse(GO);
        arm(8'hA0);
        see_status("run", 8'hA0);
        bus(16'h0F0F, 1'b0);
        bus(16'h0F0F, 1'b1);
        step(3);
        check_word("tag", 16'h0001, 16'(n_tag));
        check_flag("halted", 1'b0, halted);
        pulse(QEND);
        wait_halt();
        check_flag("tag halt", 1'b1, halted);
        pulse(GO);
        arm(8'h80);
        $display("test break done");
    endtask
    task automatic test_wait();
        pulse(WAIT_IN);
        step(2);
        see_status("wait", 8'h84);
        pulse(MFAIL);
        step(2);
        see_status("wait fail", 8'h86);
        u_host.background();
        wait_halt();
        check_flag("halted", 1'b1, halted);
        step(2);
        see_status("bg from wait", 8'hC6);
        u_host.write_ctrl(8'h00);
        see_status("write in bg", 8'hC6);
        pulse(GO);
        step(2);
        see_status("resumed", 8'h80);
        pulse(WAIT_IN);
        pulse(WAKE);
        step(2);
        see_status("woke", 8'h80);
        // enable low: command and cpu event must both be lost
        clk_en = 1'b0;
        u_host.write_ctrl(8'h38);
        pulse(WAIT_IN);
        clk_en = 1'b1;
        step(2);
        see_status("frozen", 8'h80);
        $display("test wait done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // run needs some 130 cycles, the limit allows 4000
    initial
    begin
        #20000;
        err_count++;
        complete_run();
    end
    initial
    begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        ev = 6'h00;
        cpu_addr = 16'h0000;
        addr_valid = 1'b0;
        fetch = 1'b0;
        step(2);
        reset_n = 1'b1;
        test_reset();
        test_soft_int();
        test_ctrl();
        test_break();
        test_wait();
        reset_n = 1'b0;
        step(2);
        reset_n = 1'b1;
        test_reset();
        complete_run();
    end
endmodule
